// ==== design/tmr_channel.sv ====
// one 8-bit auto-reload counter channel
// assumes ticks and writes come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module tmr_channel (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   clk_en,
	// control and count source
	input  wire tmr_pkg::tmr_chan_ctl_s ctl,
	input  wire logic                   ext_tick,
	// register writes
	input  wire logic                   count_wr,
	input  wire logic                   reload_wr,
	input  wire logic [7:0]             wdata,
	// state
	output logic      [7:0]             count_reg,
	output logic      [7:0]             reload_reg,
	output logic                        ovf_pulse_reg
);

	logic advance;

	// internal source counts every enabled cycle, external source per rising pin edge
	assign advance = clk_en && ctl.run && ctl.auto_reload && (ctl.ext_src ? ext_tick : 1'b1);

	// count byte: software write wins over a tick in the same cycle
	always_ff @(posedge clock)
	begin
		if (!resetn)
			count_reg <= tmr_pkg::RST_BYTE;
		else if (clk_en && count_wr)
			count_reg <= wdata;
		else if (advance && count_reg == tmr_pkg::CNT_ALL_ONES)
			count_reg <= reload_reg;
		else if (advance)
			count_reg <= count_reg + 8'h01;
	end

	// reload byte changes only by software
	always_ff @(posedge clock)
	begin
		if (!resetn)
			reload_reg <= tmr_pkg::RST_BYTE;
		else if (clk_en && reload_wr)
			reload_reg <= wdata;
	end

	// one-cycle overflow event
	always_ff @(posedge clock)
	begin
		if (!resetn)
			ovf_pulse_reg <= 1'b0;
		else if (clk_en)
			ovf_pulse_reg <= advance && !count_wr && count_reg == tmr_pkg::CNT_ALL_ONES;
	end

	sequence s_wrap;
		advance && !count_wr && count_reg == tmr_pkg::CNT_ALL_ONES;
	endsequence

	sequence s_step;
		advance && !count_wr && count_reg != tmr_pkg::CNT_ALL_ONES;
	endsequence

	a_wrap_reload: assert property (@(posedge clock) disable iff (!resetn)
		s_wrap |=> count_reg == $past(reload_reg) && ovf_pulse_reg)
		else $error("count not reloaded on wrap");

	a_step_inc: assert property (@(posedge clock) disable iff (!resetn)
		s_step |=> count_reg == $past(count_reg) + 8'h01 && !ovf_pulse_reg)
		else $error("count did not step by one");

	a_hold_stopped: assert property (@(posedge clock) disable iff (!resetn)
		!ctl.run && !count_wr ##1 1'b1 |-> $stable(count_reg))
		else $error("count moved while stopped");

	a_reload_kept: assert property (@(posedge clock) disable iff (!resetn)
		!(clk_en && reload_wr) |=> $stable(reload_reg))
		else $error("reload byte changed without write");

endmodule

`default_nettype wire

// ==== design/tmr_pkg.sv ====
// timer package: register map, field positions, reset values, carrier types
// assumes a single 250 MHz clock domain and an 8-bit register port
package tmr_pkg;

	// register port geometry
	localparam int unsigned ADDR_W   = 3;
	localparam int unsigned DATA_W   = 8;

	// register offsets
	localparam logic [2:0] OFF_CTRL    = 3'h0;
	localparam logic [2:0] OFF_MODE    = 3'h1;
	localparam logic [2:0] OFF_T0_CNT  = 3'h2;
	localparam logic [2:0] OFF_T0_RLD  = 3'h3;
	localparam logic [2:0] OFF_T1_CNT  = 3'h4;
	localparam logic [2:0] OFF_T1_RLD  = 3'h5;
	localparam logic [2:0] OFF_IRQ_ST  = 3'h6;
	localparam logic [2:0] OFF_IRQ_MSK = 3'h7;

	// timer_control_reg field positions
	localparam int unsigned CTRL_T0_RUN  = 4;
	localparam int unsigned CTRL_T0_FLAG = 5;
	localparam int unsigned CTRL_T1_RUN  = 6;
	localparam int unsigned CTRL_T1_FLAG = 7;

	// mode register field positions
	localparam int unsigned MODE_T0_LSB = 0;
	localparam int unsigned MODE_T0_SRC = 2;
	localparam int unsigned MODE_T1_LSB = 4;
	localparam int unsigned MODE_T1_SRC = 6;

	// interrupt status / mask bit positions
	localparam int unsigned IRQ_T0 = 0;
	localparam int unsigned IRQ_T1 = 1;

	// mode encoding and reset values
	localparam logic [1:0] MODE_AUTO_RELOAD = 2'h2;
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam logic [1:0] RST_IRQ          = 2'h0;
	localparam logic [7:0] CNT_ALL_ONES     = 8'hff;

	// per-channel control carried from the register file to a channel
	typedef struct packed {
		logic run;
		logic auto_reload;
		logic ext_src;
	} tmr_chan_ctl_s;

endpackage

// ==== design/tmr_top.sv ====
// two-channel 8-bit auto-reload timer with register port and interrupt
// assumes a one-cycle strobe master on the same clock; count pins are async
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module tmr_top #(
	parameter int unsigned ADDR_W = tmr_pkg::ADDR_W
) (
	// clock, reset, freeze
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	// external count pins
	input  wire logic              t0_pin,
	input  wire logic              t1_pin,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [7:0]        rdata_reg,
	// interrupt
	output logic                   irq_reg
);

	if (ADDR_W < 3)
		$error("ADDR_W must be at least 3");

	logic       [1:0] pin_meta_reg;
	logic       [1:0] pin_sync_reg;
	logic       [1:0] pin_last_reg;
	logic       [1:0] pin_rise;
	logic       [7:0] ctrl_reg;
	logic       [7:0] mode_reg;
	logic       [1:0] irq_st_reg;
	logic       [1:0] irq_msk_reg;
	logic       [7:0] t0_count;
	logic       [7:0] t0_reload;
	logic       [7:0] t1_count;
	logic       [7:0] t1_reload;
	logic             t0_ovf;
	logic             t1_ovf;
	logic             in_map;
	logic       [7:0] rd_mux;
	tmr_pkg::tmr_chan_ctl_s t0_ctl;
	tmr_pkg::tmr_chan_ctl_s t1_ctl;

	// write decode used for every register
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
		wr_hit = wr_stb && a == ADDR_W'(off);
	endfunction

	assign in_map = (addr >> 3) == '0; // upper index bits clear, any ADDR_W >= 3

	// two-stage synchroniser for the count pins
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			pin_meta_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
		end
		else if (clk_en)
		begin
			pin_meta_reg <= {t1_pin, t0_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// edge detector reads only the second stage
	always_ff @(posedge clock)
	begin
		if (!resetn)
			pin_last_reg <= 2'h0;
		else if (clk_en)
			pin_last_reg <= pin_sync_reg;
	end

	assign pin_rise = pin_sync_reg & ~pin_last_reg;

	// channel control bundles
	assign t0_ctl = '{run:         ctrl_reg[tmr_pkg::CTRL_T0_RUN],
	                  auto_reload: mode_reg[tmr_pkg::MODE_T0_LSB +: 2] == tmr_pkg::MODE_AUTO_RELOAD,
	                  ext_src:     mode_reg[tmr_pkg::MODE_T0_SRC]};
	assign t1_ctl = '{run:         ctrl_reg[tmr_pkg::CTRL_T1_RUN],
	                  auto_reload: mode_reg[tmr_pkg::MODE_T1_LSB +: 2] == tmr_pkg::MODE_AUTO_RELOAD,
	                  ext_src:     mode_reg[tmr_pkg::MODE_T1_SRC]};

	// channel 0
	tmr_channel u_t0 (
		.clock         (clock),
		.resetn        (resetn),
		.clk_en        (clk_en),
		.ctl           (t0_ctl),
		.ext_tick      (pin_rise[0]),
		.count_wr      (wr_hit(addr, tmr_pkg::OFF_T0_CNT)),
		.reload_wr     (wr_hit(addr, tmr_pkg::OFF_T0_RLD)),
		.wdata         (wdata),
		.count_reg     (t0_count),
		.reload_reg    (t0_reload),
		.ovf_pulse_reg (t0_ovf)
	);

	// channel 1, same logic with its own bytes and flag
	tmr_channel u_t1 (
		.clock         (clock),
		.resetn        (resetn),
		.clk_en        (clk_en),
		.ctl           (t1_ctl),
		.ext_tick      (pin_rise[1]),
		.count_wr      (wr_hit(addr, tmr_pkg::OFF_T1_CNT)),
		.reload_wr     (wr_hit(addr, tmr_pkg::OFF_T1_RLD)),
		.wdata         (wdata),
		.count_reg     (t1_count),
		.reload_reg    (t1_reload),
		.ovf_pulse_reg (t1_ovf)
	);

	// control register: run bits by software, flags set by overflow
	// a flag set in the same cycle as a software clear survives
	always_ff @(posedge clock)
	begin
		if (!resetn)
			ctrl_reg <= tmr_pkg::RST_BYTE;
		else if (clk_en)
		begin
			if (wr_hit(addr, tmr_pkg::OFF_CTRL))
				ctrl_reg <= wdata & 8'hf0;
			if (t0_ovf)
				ctrl_reg[tmr_pkg::CTRL_T0_FLAG] <= 1'b1;
			if (t1_ovf)
				ctrl_reg[tmr_pkg::CTRL_T1_FLAG] <= 1'b1;
		end
	end

	// mode and source select
	always_ff @(posedge clock)
	begin
		if (!resetn)
			mode_reg <= tmr_pkg::RST_BYTE;
		else if (clk_en && wr_hit(addr, tmr_pkg::OFF_MODE))
			mode_reg <= wdata & 8'h77;
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge clock)
	begin
		if (!resetn)
			irq_st_reg <= tmr_pkg::RST_IRQ;
		else if (clk_en)
			irq_st_reg <= (irq_st_reg & ~(wr_hit(addr, tmr_pkg::OFF_IRQ_ST) ? wdata[1:0] : 2'h0))
			              | {t1_ovf, t0_ovf};
	end

	// interrupt enables
	always_ff @(posedge clock)
	begin
		if (!resetn)
			irq_msk_reg <= tmr_pkg::RST_IRQ;
		else if (clk_en && wr_hit(addr, tmr_pkg::OFF_IRQ_MSK))
			irq_msk_reg <= wdata[1:0];
	end

	// level interrupt, registered so it trails status by one cycle
	always_ff @(posedge clock)
	begin
		if (!resetn)
			irq_reg <= 1'b0;
		else if (clk_en)
			irq_reg <= |(irq_st_reg & irq_msk_reg);
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (in_map)
			unique case (addr[2:0])
				tmr_pkg::OFF_CTRL:    rd_mux = ctrl_reg;
				tmr_pkg::OFF_MODE:    rd_mux = mode_reg;
				tmr_pkg::OFF_T0_CNT:  rd_mux = t0_count;
				tmr_pkg::OFF_T0_RLD:  rd_mux = t0_reload;
				tmr_pkg::OFF_T1_CNT:  rd_mux = t1_count;
				tmr_pkg::OFF_T1_RLD:  rd_mux = t1_reload;
				tmr_pkg::OFF_IRQ_ST:  rd_mux = {6'h00, irq_st_reg};
				tmr_pkg::OFF_IRQ_MSK: rd_mux = {6'h00, irq_msk_reg};
			endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!resetn)
			rdata_reg <= 8'h00;
		else if (clk_en)
			rdata_reg <= rd_stb ? rd_mux : 8'h00;
	end

	sequence s_t0_over;
		clk_en && t0_ovf;
	endsequence

	sequence s_t1_over;
		clk_en && t1_ovf;
	endsequence

	a_t0_flag_set: assert property (@(posedge clock) disable iff (!resetn)
		s_t0_over |=> ctrl_reg[tmr_pkg::CTRL_T0_FLAG] && irq_st_reg[tmr_pkg::IRQ_T0])
		else $error("channel 0 flag not set on overflow");

	a_t1_flag_set: assert property (@(posedge clock) disable iff (!resetn)
		s_t1_over |=> ctrl_reg[tmr_pkg::CTRL_T1_FLAG] && irq_st_reg[tmr_pkg::IRQ_T1])
		else $error("channel 1 flag not set on overflow");

	a_irq_raised: assert property (@(posedge clock) disable iff (!resetn)
		s_t0_over ##0 irq_msk_reg[tmr_pkg::IRQ_T0] && !wr_hit(addr, tmr_pkg::OFF_IRQ_MSK) ##1 clk_en
		|=> irq_reg)
		else $error("enabled overflow raised no interrupt");

	a_irq_quiet: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && (irq_st_reg & irq_msk_reg) == 2'h0 |=> !irq_reg)
		else $error("interrupt without enabled status");

	a_read_timing: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && !rd_stb |=> rdata_reg == 8'h00)
		else $error("read data outside its cycle");

	sequence s_t1_armed;
		clk_en && t1_ovf && irq_msk_reg[tmr_pkg::IRQ_T1] && !wr_hit(addr, tmr_pkg::OFF_IRQ_MSK);
	endsequence

	// channel 1 overflow with its interrupt enabled reaches the pin two cycles on
	a_t1_irq_raised: assert property (@(posedge clock) disable iff (!resetn)
		s_t1_armed ##1 clk_en |=> irq_reg)
		else $error("enabled channel 1 overflow raised no interrupt");

	// any enabled pending status drives the interrupt on the next cycle
	a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && (irq_st_reg & irq_msk_reg) != 2'h0 |=> irq_reg)
		else $error("enabled status without interrupt");

	// write one clears a status bit unless a new overflow lands with it
	a_st_clear: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && wr_hit(addr, tmr_pkg::OFF_IRQ_ST) && wdata[tmr_pkg::IRQ_T0] && !t0_ovf
		|=> !irq_st_reg[tmr_pkg::IRQ_T0])
		else $error("status bit not cleared by write one");

	// status holds until software clears it
	a_st_sticky: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && irq_st_reg[tmr_pkg::IRQ_T0] && !(wr_hit(addr, tmr_pkg::OFF_IRQ_ST) && wdata[tmr_pkg::IRQ_T0])
		|=> irq_st_reg[tmr_pkg::IRQ_T0])
		else $error("channel 0 status dropped on its own");

	// same stickiness for channel 1
	a_t1_st_sticky: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && irq_st_reg[tmr_pkg::IRQ_T1] && !(wr_hit(addr, tmr_pkg::OFF_IRQ_ST) && wdata[tmr_pkg::IRQ_T1])
		|=> irq_st_reg[tmr_pkg::IRQ_T1])
		else $error("channel 1 status dropped on its own");

	// hardware never clears an overflow flag
	a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && ctrl_reg[tmr_pkg::CTRL_T0_FLAG] && !wr_hit(addr, tmr_pkg::OFF_CTRL)
		|=> ctrl_reg[tmr_pkg::CTRL_T0_FLAG])
		else $error("channel 0 flag dropped on its own");

	// a written zero clears the flag when no overflow competes
	a_flag_clear: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && wr_hit(addr, tmr_pkg::OFF_CTRL) && !wdata[tmr_pkg::CTRL_T0_FLAG] && !t0_ovf
		|=> !ctrl_reg[tmr_pkg::CTRL_T0_FLAG])
		else $error("channel 0 flag not cleared by software");

	// same clear path for channel 1
	a_t1_flag_clear: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && wr_hit(addr, tmr_pkg::OFF_CTRL) && !wdata[tmr_pkg::CTRL_T1_FLAG] && !t1_ovf
		|=> !ctrl_reg[tmr_pkg::CTRL_T1_FLAG])
		else $error("channel 1 flag not cleared by software");

	// only the auto-reload mode counts; other codes hold the byte
	a_t0_mode_hold: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && !t0_ctl.auto_reload && !wr_hit(addr, tmr_pkg::OFF_T0_CNT) |=> $stable(t0_count))
		else $error("channel 0 counted outside auto-reload mode");

	// channel 1 obeys its own mode field
	a_t1_mode_hold: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && !t1_ctl.auto_reload && !wr_hit(addr, tmr_pkg::OFF_T1_CNT) |=> $stable(t1_count))
		else $error("channel 1 counted outside auto-reload mode");

	// a count read returns the running byte of the strobe cycle
	a_t0_read_cnt: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && rd_stb && addr == ADDR_W'(tmr_pkg::OFF_T0_CNT) |=> rdata_reg == $past(t0_count))
		else $error("count byte read wrong");

	// a reload read returns the stored start value
	a_t1_read_rld: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && rd_stb && addr == ADDR_W'(tmr_pkg::OFF_T1_RLD) |=> rdata_reg == $past(t1_reload))
		else $error("reload byte read wrong");

	// a low clock enable freezes every visible register
	a_freeze_all: assert property (@(posedge clock) disable iff (!resetn)
		!clk_en |=> $stable(ctrl_reg) && $stable(irq_st_reg) && $stable(rdata_reg) && $stable(irq_reg)
		&& $stable(t0_count) && $stable(t1_count))
		else $error("state moved while frozen");

	// a held pin level gives exactly one tick
	a_edge_once: assert property (@(posedge clock) disable iff (!resetn)
		clk_en && pin_rise[0] |=> !pin_rise[0])
		else $error("one pin edge gave two ticks");

endmodule

`default_nettype wire

// ==== verification/test_timer_8bit_auto_reload.sv ====
// self-checking bench for the two-channel 8-bit auto-reload timer
// assumes tmr_pkg and tmr_top are compiled first; the bench drives every port itself
`timescale 1ns/1ns
`default_nettype none

module test_timer_8bit_auto_reload;
	// clock, reset, freeze
	logic                        clock       = 1'b0;
	logic                        resetn      = 1'b0;
	logic                        clk_en      = 1'b1;
	// count pins
	logic                        t0_pin      = 1'b0;
	logic                        t1_pin      = 1'b0;
	// register port
	logic [tmr_pkg::ADDR_W-1:0]  addr        = 3'h0;
	logic [7:0]                  wdata       = 8'h00;
	logic                        wr_stb      = 1'b0;
	logic                        rd_stb      = 1'b0;
	logic [7:0]                  rdata_reg;
	logic                        irq_reg;
	// bookkeeping
	int                          num_errors  = 0;
	int                          checks_done = 0;
	int                          cycles      = 0;

	// 250 MHz clock
	always #2 clock = ~clock;

	tmr_top #(.ADDR_W(tmr_pkg::ADDR_W)) u_dut (
		.clock     (clock),
		.resetn    (resetn),
		.clk_en    (clk_en),
		.t0_pin    (t0_pin),
		.t1_pin    (t1_pin),
		.addr      (addr),
		.wdata     (wdata),
		.wr_stb    (wr_stb),
		.rd_stb    (rd_stb),
		.rdata_reg (rdata_reg),
		.irq_reg   (irq_reg)
	);

	// verdict and end of run, reached from the main sequence or the watchdog
	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one comparison, four-state exact
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// write: one strobe cycle, then one idle cycle so strobes never collide in a time step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		@(posedge clock);
		#1;
	endtask

	// read: data stands only in the cycle after the strobe, so sample just after that edge
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		check(rdata_reg, exp);
		@(posedge clock);
		#1;
	endtask

	// internal-source run of k = m + 2 - f ticks, f cycles frozen, stopped by a mode write
	// um unmasks the channel's interrupt while it counts
	task automatic run_chan(input int ch, input logic [7:0] start, input logic [7:0] rld,
		input int m, input int f, input logic um);
		logic [2:0] oc    = ch ? tmr_pkg::OFF_T1_CNT : tmr_pkg::OFF_T0_CNT;
		logic [2:0] orl   = ch ? tmr_pkg::OFF_T1_RLD : tmr_pkg::OFF_T0_RLD;
		logic [7:0] runb  = 8'h01 << (ch ? tmr_pkg::CTRL_T1_RUN : tmr_pkg::CTRL_T0_RUN);
		logic [7:0] flagb = 8'h01 << (ch ? tmr_pkg::CTRL_T1_FLAG : tmr_pkg::CTRL_T0_FLAG);
		logic [7:0] modev = {6'h00, tmr_pkg::MODE_AUTO_RELOAD} << (ch ? tmr_pkg::MODE_T1_LSB : 0);
		logic [7:0] irqb  = 8'h01 << (ch ? tmr_pkg::IRQ_T1 : tmr_pkg::IRQ_T0);
		logic [7:0] cnt   = start;
		logic       ovf   = 1'b0;
		repeat (m + 2 - f)
		begin
			ovf = ovf | (cnt == 8'hff);
			cnt = (cnt == 8'hff) ? rld : cnt + 8'h01;
		end
		wr(orl, rld);
		wr(oc, start);
		wr(tmr_pkg::OFF_MODE, modev);
		if (um)
			wr(tmr_pkg::OFF_IRQ_MSK, irqb);
		wr(tmr_pkg::OFF_CTRL, runb);
		clk_en <= 1'b0;
		repeat (f) @(posedge clock);
		clk_en <= 1'b1;
		repeat (m - f) @(posedge clock);
		wr(tmr_pkg::OFF_MODE, 8'h00);
		check({7'h00, irq_reg}, {7'h00, ovf & um});
		wr(tmr_pkg::OFF_IRQ_MSK, 8'h00);
		rd_chk(oc, cnt);
		rd_chk(orl, rld);
		rd_chk(tmr_pkg::OFF_CTRL, runb | (ovf ? flagb : 8'h00));
		rd_chk(tmr_pkg::OFF_IRQ_ST, ovf ? irqb : 8'h00);
		check({7'h00, irq_reg}, 8'h00);
		// unmask, then acknowledge
		wr(tmr_pkg::OFF_IRQ_MSK, irqb);
		check({7'h00, irq_reg}, {7'h00, ovf});
		wr(tmr_pkg::OFF_IRQ_ST, irqb);
		check({7'h00, irq_reg}, 8'h00);
		wr(tmr_pkg::OFF_IRQ_MSK, 8'h00);
		// run bit off: selected mode alone must not count
		wr(tmr_pkg::OFF_CTRL, 8'h00);
		wr(tmr_pkg::OFF_MODE, modev);
		repeat (5) @(posedge clock);
		rd_chk(oc, cnt);
		rd_chk(tmr_pkg::OFF_CTRL, 8'h00);
		wr(tmr_pkg::OFF_MODE, 8'h00);
	endtask

	// pin-source run: three slow pulses give three ticks
	task automatic pin_chan(input int ch, input logic [7:0] start);
		logic [2:0] oc    = ch ? tmr_pkg::OFF_T1_CNT : tmr_pkg::OFF_T0_CNT;
		logic [7:0] runb  = 8'h01 << (ch ? tmr_pkg::CTRL_T1_RUN : tmr_pkg::CTRL_T0_RUN);
		logic [7:0] modev = {6'h00, tmr_pkg::MODE_AUTO_RELOAD} << (ch ? tmr_pkg::MODE_T1_LSB : 0);
		logic [7:0] srcb  = 8'h01 << (ch ? tmr_pkg::MODE_T1_SRC : tmr_pkg::MODE_T0_SRC);
		wr(oc, start);
		wr(tmr_pkg::OFF_MODE, modev | srcb);
		wr(tmr_pkg::OFF_CTRL, runb);
		repeat (3)
		begin
			if (ch) t1_pin <= 1'b1; else t0_pin <= 1'b1;
			repeat (4) @(posedge clock);
			if (ch) t1_pin <= 1'b0; else t0_pin <= 1'b0;
			repeat (4) @(posedge clock);
		end
		repeat (6) @(posedge clock);
		wr(tmr_pkg::OFF_MODE, 8'h00);
		rd_chk(oc, start + 8'h03);
		wr(tmr_pkg::OFF_CTRL, 8'h00);
	endtask

	// watchdog: whole sequence needs well under 20000 cycles
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			summarize();
		end
	end

	// main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		#1;
		for (int a = 0; a < 8; a++)
			rd_chk(a[2:0], tmr_pkg::RST_BYTE);
		for (int ch = 0; ch < 2; ch++)
		begin
			run_chan(ch, 8'hfd, 8'hf0, 6, 1, 1'b1);
			run_chan(ch, 8'hfe, 8'hfe, 5, 2, 1'b0);
			run_chan(ch, 8'h10, 8'h80, 3, 1, 1'b0);
			pin_chan(ch, 8'h20);
		end
		summarize();
	end
endmodule

`default_nettype wire
